// ---- core/clbi_arb_if.sv ----
`default_nettype none
// ---------------------------------------------------------------
// ownership handshake between cycle engine and pin arbiter
// ---------------------------------------------------------------
interface clbi_arb_if;
  logic own_req;      // engine wants the bus
  logic owned;        // arbiter holds the bus for the engine
  logic cycles_done;  // last own cycle finishing (T4)
  modport eng (output own_req, output cycles_done, input owned);
  modport arb (input own_req, input cycles_done, output owned);
endinterface
`default_nettype wire

// ---- core/clbi_pkg.sv ----
`default_nettype none
package clbi_pkg;
  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int AD_W   = 16;                  // shared address/data lines
  localparam int UP_W   = 4;                   // upper address/status lines
  localparam int ADDR_W = AD_W + UP_W;         // full memory address
  localparam int BE_W   = 2;                   // byte lanes
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LO_BYTE = 0;                  // lane of bits 7..0
  localparam int HI_BYTE = 1;                  // lane of bits 15..8
  localparam int A0_POS  = 0;                  // lowest address bit
  localparam int UB_LSB  = 8;                  // upper byte address low bit
  // ---------------------------------------------------------------
  // status values driven in own cycles, T2..T4
  // ---------------------------------------------------------------
  // line3..line0 carry s6 s5 s4 s3: s6,s4,s3 high, s5 low
  localparam logic [UP_W-1:0] OWN_STATUS = 4'hB;
  localparam logic            OWN_S7     = 1'h0; // s7 level in own cycles
  // ---------------------------------------------------------------
  // request/grant pin levels and timing
  // ---------------------------------------------------------------
  localparam logic RQ_PULSE_LVL = 1'h0;        // pulses are active low
  localparam int   DEAD_CLKS    = 1;           // idle clocks after exchange
  // ---------------------------------------------------------------
  // bus cycle states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CLBI_TI, CLBI_T1, CLBI_T2, CLBI_T3, CLBI_TW, CLBI_T4
  } clbi_tstate_e;
endpackage
`default_nettype wire

// ---- core/clbi_rqgt.sv ----
`default_nettype none
// ---------------------------------------------------------------
// request/grant pin arbiter for cpu side and master side
// ---------------------------------------------------------------
module clbi_rqgt
  import clbi_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // engine handshake
  clbi_arb_if.arb   arb,
  // cpu side request/grant pin
  input  wire logic cpu_rg_n_i,
  output logic      cpu_rg_n_oe,
  // master side request/grant pin
  input  wire logic mst_rg_n_i,
  output logic      mst_rg_n_oe
);
  import clbi_pkg::*;

  typedef enum logic [3:0] {
    RG_IDLE, RG_REQ, RG_WGNT, RG_OWN, RG_RDLY, RG_RBUS, RG_REL, RG_DEAD
  } clbi_rg_e;

  clbi_rg_e st_r, st_nxt;       // arbiter state
  logic     relay_r, relay_nxt; // exchange made for the other master
  logic     cpu_pl_r, cpu_pl_nxt; // pulse on cpu pin
  logic     mst_pl_r, mst_pl_nxt; // pulse on master pin
  logic     dead_r;             // dead clock counter (one bit suffices)

  // pin levels seen as pulses
  wire cpu_pulse = (cpu_rg_n_i == RQ_PULSE_LVL);
  wire mst_pulse = (mst_rg_n_i == RQ_PULSE_LVL);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    relay_nxt  = relay_r;
    cpu_pl_nxt = 1'b0;
    mst_pl_nxt = 1'b0;
    unique case (st_r)
      RG_IDLE: begin
        if (mst_pulse) begin
          // master request passed one cycle later
          cpu_pl_nxt = 1'b1;
          relay_nxt  = 1'b1;
          st_nxt     = RG_REQ;
        end else if (arb.own_req) begin
          cpu_pl_nxt = 1'b1;
          relay_nxt  = 1'b0;
          st_nxt     = RG_REQ;
        end
      end
      // own pulse on the pin, do not sample it
      RG_REQ: st_nxt = RG_WGNT;
      RG_WGNT: begin
        if (cpu_pulse) begin
          st_nxt = relay_r ? RG_RDLY : RG_OWN;
        end
      end
      // grant passed with two clocks delay
      RG_RDLY: begin
        mst_pl_nxt = 1'b1;
        st_nxt     = RG_RBUS;
      end
      // master release relayed one clock later
      RG_RBUS: begin
        if (!mst_pl_r && mst_pulse) begin
          cpu_pl_nxt = 1'b1;
          st_nxt     = RG_REL;
        end
      end
      // release one clock after last cycle
      RG_OWN: begin
        if (arb.cycles_done) begin
          cpu_pl_nxt = 1'b1;
          st_nxt     = RG_REL;
        end
      end
      RG_REL:  st_nxt = RG_DEAD;
      RG_DEAD: st_nxt = dead_r ? RG_DEAD : RG_IDLE;
      default: st_nxt = RG_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= RG_IDLE;
      relay_r  <= 1'b0;
      cpu_pl_r <= 1'b0;
      mst_pl_r <= 1'b0;
      dead_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      relay_r  <= relay_nxt;
      cpu_pl_r <= cpu_pl_nxt;
      mst_pl_r <= mst_pl_nxt;
      dead_r   <= (st_nxt == RG_DEAD) && (st_r != RG_DEAD) && (DEAD_CLKS > 1);
    end
  end

  // engine may start in the clock after the grant
  assign arb.owned = (st_r == RG_OWN);
  // pins only pulled low, one clock each
  assign cpu_rg_n_oe = cpu_pl_r;
  assign mst_rg_n_oe = mst_pl_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_req_one_clk: assert property (cpu_pl_r |=> !cpu_pl_r)
    else $error("cpu pin pulse longer than one clock");
  chk_own_after_gnt: assert property (
    st_r == RG_WGNT && cpu_pulse && !relay_r |=> arb.owned)
    else $error("bus not taken in clock after grant");
  chk_relay_gnt: assert property (
    st_r == RG_WGNT && cpu_pulse && relay_r |-> ##2 mst_pl_r)
    else $error("relayed grant not two clocks later");
  chk_release_pulse: assert property (
    st_r == RG_OWN && arb.cycles_done |=> cpu_pl_r ##1 !arb.owned)
    else $error("no release one clock after last cycle");
  chk_dead_clock: assert property (
    st_r == RG_REL |=> !cpu_pl_r && !mst_pl_r ##1 !cpu_pl_r)
    else $error("no dead clock after exchange");
  chk_relay_req: assert property (
    st_r == RG_IDLE && mst_pulse |=> cpu_pl_r)
    else $error("master request not passed one cycle later");

  cov_own_xchg: cover property (st_r == RG_OWN ##[1:200] st_r == RG_REL);
  cov_relay: cover property (st_r == RG_RBUS ##[1:200] st_r == RG_REL);
endmodule
`default_nettype wire

// ---- core/clbi_top.sv ----
`default_nettype none
module clbi_top
  import clbi_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0           // eight bit host data bus
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // transfer request from the core
  input  wire logic                  xfer_valid,
  output logic                       xfer_ready,
  input  wire logic [ADDR_W-1:0]     xfer_addr,
  input  wire logic [BE_W-1:0]       xfer_be,
  input  wire logic                  xfer_write,
  input  wire logic                  xfer_last,
  input  wire logic [AD_W-1:0]       xfer_wdata,
  // transfer answer
  output logic                       xfer_done,
  output logic [AD_W-1:0]            xfer_rdata,
  // wait state request from memory
  input  wire logic                  bus_ready,
  // bus monitor while cpu owns the bus
  output logic [AD_W-1:0]            mon_ad,
  output logic [UP_W:0]              mon_status,
  // shared address/data lines
  input  wire logic [AD_W-1:0]       shared_addr_data_lines_i,
  output logic [AD_W-1:0]            shared_addr_data_lines_o,
  output logic [AD_W-1:0]            shared_addr_data_lines_oe,
  // upper address/status lines 3..0
  input  wire logic [UP_W-1:0]       upper_addr_status_lines_i,
  output logic [UP_W-1:0]            upper_addr_status_lines_o,
  output logic [UP_W-1:0]            upper_addr_status_lines_oe,
  // high byte enable / status, active low enable
  input  wire logic                  high_byte_enable_status_n_i,
  output logic                       high_byte_enable_status_n_o,
  output logic                       high_byte_enable_status_n_oe,
  // request/grant pins, active low
  input  wire logic                  cpu_side_request_grant_n_i,
  output logic                       cpu_side_request_grant_n_o,
  output logic                       cpu_side_request_grant_n_oe,
  input  wire logic                  master_side_request_grant_n_i,
  output logic                       master_side_request_grant_n_o,
  output logic                       master_side_request_grant_n_oe
);
  import clbi_pkg::*;

  // ---------------------------------------------------------------
  // state and captured transfer
  // ---------------------------------------------------------------
  clbi_tstate_e          st_r, st_nxt;  // bus cycle state
  logic [ADDR_W-1:0]     addr_r;        // captured address
  logic [BE_W-1:0]       be_r;          // captured byte lanes
  logic                  wr_r;          // captured direction
  logic                  last_r;        // last cycle of the exchange
  logic [AD_W-1:0]       wdata_r;       // captured write data
  logic [AD_W-1:0]       rdata_r;       // read data
  logic                  done_r;        // transfer done pulse
  logic [AD_W-1:0]       mon_ad_r;      // monitored address/data
  logic [UP_W:0]         mon_st_r;      // monitored s7 and upper lines

  clbi_arb_if arb_if ();

  // ---------------------------------------------------------------
  // pin arbiter
  // ---------------------------------------------------------------
  clbi_rqgt u_rqgt (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .arb         (arb_if),
    .cpu_rg_n_i  (cpu_side_request_grant_n_i),
    .cpu_rg_n_oe (cpu_side_request_grant_n_oe),
    .mst_rg_n_i  (master_side_request_grant_n_i),
    .mst_rg_n_oe (master_side_request_grant_n_oe)
  );

  assign cpu_side_request_grant_n_o    = RQ_PULSE_LVL;
  assign master_side_request_grant_n_o = RQ_PULSE_LVL;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire owned    = arb_if.owned;
  wire in_t1    = (st_r == CLBI_T1);
  wire in_data  = (st_r == CLBI_T2) || (st_r == CLBI_T3) ||
                  (st_r == CLBI_TW) || (st_r == CLBI_T4);
  wire in_cycle = in_t1 || in_data;
  wire accept   = xfer_valid && xfer_ready;
  wire smp_data = (st_r == CLBI_T3 || st_r == CLBI_TW) && bus_ready;

  // ask for the bus when work waits and bus not held
  assign arb_if.own_req     = xfer_valid && !owned;
  assign arb_if.cycles_done = (st_r == CLBI_T4) && last_r;
  assign xfer_ready         = owned && (st_r == CLBI_TI);

  // ---------------------------------------------------------------
  // bus cycle sequence
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      CLBI_TI: if (accept) st_nxt = CLBI_T1;
      CLBI_T1: st_nxt = CLBI_T2;
      CLBI_T2: st_nxt = CLBI_T3;
      // wait states until memory ready
      CLBI_T3: st_nxt = bus_ready ? CLBI_T4 : CLBI_TW;
      CLBI_TW: st_nxt = bus_ready ? CLBI_T4 : CLBI_TW;
      CLBI_T4: st_nxt = CLBI_TI;
    endcase
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // address in T1, write data afterwards
  // lowest bit low when low lane moves
  wire [AD_W-1:0] t1_ad   = {addr_r[AD_W-1:1], ~be_r[LO_BYTE]};
  // narrow bus keeps upper address byte through T4
  wire [AD_W-1:0] data_ad = NARROW_BUS ?
                            {addr_r[AD_W-1:UB_LSB], wdata_r[UB_LSB-1:0]} : wdata_r;
  wire [AD_W-1:0] hi_oe   = (NARROW_BUS || wr_r) ? {AD_W{1'b1}} : {AD_W{1'b0}};
  wire [AD_W-1:0] lo_oe   = wr_r ? {AD_W{1'b1}} : {AD_W{1'b0}};
  wire [AD_W-1:0] data_oe = {hi_oe[AD_W-1:UB_LSB], lo_oe[UB_LSB-1:0]};

  assign shared_addr_data_lines_o  = in_t1 ? t1_ad : data_ad;
  assign shared_addr_data_lines_oe = !owned  ? {AD_W{1'b0}} :
                                     in_t1   ? {AD_W{1'b1}} :
                                     in_data ? data_oe : {AD_W{1'b0}};
  // upper address in T1, status afterwards
  assign upper_addr_status_lines_o  = in_t1 ? addr_r[ADDR_W-1:AD_W] : OWN_STATUS;
  assign upper_addr_status_lines_oe = (owned && in_cycle) ? {UP_W{1'b1}} : {UP_W{1'b0}};
  // high byte enable low in T1 when high lane moves
  assign high_byte_enable_status_n_o  = in_t1 ? ~be_r[HI_BYTE] : OWN_S7;
  assign high_byte_enable_status_n_oe = owned && in_cycle;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= CLBI_TI;
      addr_r  <= '0;
      be_r    <= '0;
      wr_r    <= 1'b0;
      last_r  <= 1'b0;
      wdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      // capture transfer at acceptance
      if (accept) begin
        addr_r  <= xfer_addr;
        be_r    <= xfer_be;
        wr_r    <= xfer_write;
        last_r  <= xfer_last;
        wdata_r <= xfer_wdata;
      end
    end
  end

  // read data capture and done pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      done_r  <= 1'b0;
    end else begin
      if (smp_data && !wr_r) rdata_r <= shared_addr_data_lines_i;
      done_r <= (st_r == CLBI_T4);
    end
  end

  // monitor lines while cpu holds the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_ad_r <= '0;
      mon_st_r <= '0;
    end else if (!owned) begin
      mon_ad_r <= shared_addr_data_lines_i;
      mon_st_r <= {high_byte_enable_status_n_i, upper_addr_status_lines_i};
    end
  end

  assign xfer_done  = done_r;
  assign xfer_rdata = rdata_r;
  assign mon_ad     = mon_ad_r;
  assign mon_status = mon_st_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_t1_address: assert property (in_t1 |->
    &shared_addr_data_lines_oe && shared_addr_data_lines_o[15:1] == addr_r[15:1])
    else $error("address not driven in T1");
  chk_a0_low_byte: assert property (in_t1 && be_r[LO_BYTE] |->
    !shared_addr_data_lines_o[A0_POS])
    else $error("lowest address bit not low for low byte");
  chk_float_cpu: assert property (!owned |->
    shared_addr_data_lines_oe == '0 && upper_addr_status_lines_oe == '0 &&
    !high_byte_enable_status_n_oe)
    else $error("bus driven while not owned");
  chk_status_bits: assert property (in_data |->
    upper_addr_status_lines_o == 4'hB && &upper_addr_status_lines_oe)
    else $error("own status bits wrong");
  chk_bhe_t1: assert property (in_t1 && be_r[HI_BYTE] |->
    !high_byte_enable_status_n_o && high_byte_enable_status_n_oe)
    else $error("high byte enable not low in T1");
  chk_cycle_order: assert property (accept |=> in_t1 ##1 st_r == CLBI_T2
    ##1 st_r == CLBI_T3)
    else $error("bus cycle states out of order");
  chk_narrow_upper: assert property (NARROW_BUS && in_cycle |->
    shared_addr_data_lines_o[15:8] == addr_r[15:8])
    else $error("upper address byte not held");

  cov_wait_state: cover property (st_r == CLBI_TW ##1 st_r == CLBI_T4);
  cov_read_done: cover property (accept && !xfer_write ##[4:40] xfer_done);
endmodule
`default_nettype wire

// ---- tb/clbi_host_model.sv ----
`default_nettype none
// ---------------------------------------------------------------
// host cpu and second bus master on the request/grant pins
// ---------------------------------------------------------------
module clbi_host_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // resolved pins, pulled up when nobody pulls
  input  wire logic       cpu_rg_n,
  input  wire logic       mst_rg_n,
  // bench control: master request start, grant and hold delay
  input  wire logic       mst_go,
  input  wire logic [3:0] dly,
  // pulls a pin low for one clock
  output var  logic       cpu_pull,
  output var  logic       mst_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cpu_st_r;   // 0 idle, 1 delay, 2 own grant, 3 bus lent
  logic [1:0] mst_st_r;   // 0 idle, 1 own request, 2 wait grant, 3 hold
  logic [3:0] cpu_cnt_r;  // grant delay left
  logic [3:0] mst_cnt_r;  // hold time left
  // cpu: one grant pulse after a request, then wait for the release
  // low grant pulse one clock wide
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cpu_st_r, cpu_cnt_r, cpu_pull} <= 7'h00;
    end else begin
      cpu_pull <= 1'b0;
      case (cpu_st_r)
        2'h0: if (!cpu_rg_n) begin
          {cpu_st_r, cpu_cnt_r} <= {2'h1, dly};
        end
        2'h1: if (cpu_cnt_r == 4'h0) begin
          {cpu_st_r, cpu_pull} <= 3'h5;
        end else begin
          cpu_cnt_r <= cpu_cnt_r - 4'h1;
        end
        2'h2: cpu_st_r <= 2'h3;              // our own grant is on the pin
        default: if (!cpu_rg_n) begin
          cpu_st_r <= 2'h0;                  // release seen, bus back
        end
      endcase
    end
  end
  // master: request, wait for grant, hold, release
  // two low pulses, request and release, bench spaces exchanges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {mst_st_r, mst_cnt_r, mst_pull} <= 7'h00;
    end else begin
      mst_pull <= 1'b0;
      case (mst_st_r)
        2'h0: if (mst_go) begin
          {mst_st_r, mst_pull} <= 3'h3;
        end
        2'h1: mst_st_r <= 2'h2;              // our own request is on the pin
        2'h2: if (!mst_rg_n) begin
          {mst_st_r, mst_cnt_r} <= {2'h3, dly};
        end
        default: if (mst_cnt_r == 4'h0) begin
          {mst_st_r, mst_pull} <= 3'h1;
        end else begin
          mst_cnt_r <= mst_cnt_r - 4'h1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/clbi_top_tb_top.sv ----
`default_nettype none
// ---------------------------------------------------------------
// bench for the coprocessor local bus side
// ---------------------------------------------------------------
module clbi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clbi_pkg::*;
  logic              ref_clk, rst_n, bus_ready;                 // clock, reset, memory
  logic              xfer_valid, xfer_write, xfer_last;         // core request
  logic              xfer_ready, xfer_done;                     // core answer
  logic [ADDR_W-1:0] xfer_addr;
  logic [BE_W-1:0]   xfer_be;
  logic [AD_W-1:0]   xfer_wdata, xfer_rdata, mon_ad;
  logic [UP_W:0]     mon_status;
  logic [AD_W-1:0]   ad_o, ad_oe, ad_w, tb_ad;                  // shared lines
  logic [UP_W-1:0]   up_o, up_oe, up_w, tb_up;                  // upper lines
  logic              hb_o, hb_oe, hb_w, tb_hb;                  // high byte enable
  logic              cg_o, cg_oe, cg_w, cpu_pull;               // cpu side pin
  logic              mg_o, mg_oe, mg_w, mst_pull;               // master side pin
  logic              mst_go;
  logic [3:0]        dly;
  logic [41:0]       drv;                                       // what the device drives
  int                n_fail = 0;
  int                checked = 0;
  int                n_low = 0;                                 // cpu pin low clocks
  // wire levels: device where enabled, else the far side or pull-up
  assign ad_w = (ad_oe & ad_o) | (~ad_oe & tb_ad);
  assign up_w = (up_oe & up_o) | (~up_oe & tb_up);
  assign hb_w = hb_oe ? hb_o : tb_hb;
  assign cg_w = ~((cg_oe & ~cg_o) | cpu_pull);
  assign mg_w = ~((mg_oe & ~mg_o) | mst_pull);
  assign drv  = {ad_oe, ad_oe & ad_o, up_oe, up_o, hb_oe, hb_o};
  clbi_top u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
    .xfer_addr(xfer_addr), .xfer_be(xfer_be), .xfer_write(xfer_write),
    .xfer_last(xfer_last), .xfer_wdata(xfer_wdata), .xfer_done(xfer_done),
    .xfer_rdata(xfer_rdata), .bus_ready(bus_ready), .mon_ad(mon_ad), .mon_status(mon_status),
    .shared_addr_data_lines_i(ad_w), .shared_addr_data_lines_o(ad_o),
    .shared_addr_data_lines_oe(ad_oe), .upper_addr_status_lines_i(up_w),
    .upper_addr_status_lines_o(up_o), .upper_addr_status_lines_oe(up_oe),
    .high_byte_enable_status_n_i(hb_w), .high_byte_enable_status_n_o(hb_o),
    .high_byte_enable_status_n_oe(hb_oe), .cpu_side_request_grant_n_i(cg_w),
    .cpu_side_request_grant_n_o(cg_o), .cpu_side_request_grant_n_oe(cg_oe),
    .master_side_request_grant_n_i(mg_w), .master_side_request_grant_n_o(mg_o),
    .master_side_request_grant_n_oe(mg_oe));
  clbi_host_model u_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .cpu_rg_n(cg_w), .mst_rg_n(mg_w),
    .mst_go(mst_go), .dly(dly), .cpu_pull(cpu_pull), .mst_pull(mst_pull));
  // clock and a count of low clocks on the cpu pin
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cg_w === 1'b0) n_low <= n_low + 1;
  end
  // compare one result and count it
  task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts, verdict, end of run
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one own bus cycle; fresh asks the cpu for the bus first
  task automatic own_xfer(input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
      input logic wr, input logic lst, input logic [AD_W-1:0] d, input int waits,
      input logic fresh);
    logic [AD_W-1:0] m;
    m = wr ? 16'hFFFF : 16'h0000;
    {xfer_valid, xfer_addr, xfer_be, xfer_write, xfer_last, xfer_wdata} =
        {1'b1, a, be, wr, lst, d};
    tb_ad = d;
    if (fresh) begin
      for (int i = 0; i < 20 && cg_oe !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("request width", cg_oe, 1'b0);
      for (int i = 0; i < 20 && cpu_pull !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
    end
    chk("ready", xfer_ready, 1'b1);
    @(negedge ref_clk);
    xfer_valid = 1'b0;
    chk("t1 pins", drv, {16'hFFFF, a[15:0], 4'hF, a[19:16], 1'b1, ~be[1]});
    for (int i = 0; i < waits + 3; i++) begin
      @(negedge ref_clk);
      bus_ready = (i == 0) || (i > waits);
      chk("data phase", {drv, xfer_done}, {m, m & d, 4'hF, OWN_STATUS, 1'b1, OWN_S7, 1'b0});
    end
    @(negedge ref_clk);
    chk("done", xfer_done, 1'b1);
    if (!wr) chk("read data", xfer_rdata, d);
    if (lst) begin
      chk("release", {cg_oe, ad_oe, up_oe, hb_oe}, 22'h200000);
      @(negedge ref_clk);
      chk("release width", cg_oe, 1'b0);
    end else begin
      chk("bus kept", {cg_oe, xfer_ready}, 2'h1);
    end
  endtask
  // drivers off and monitor follows the pins while the cpu owns the bus
  task automatic t_monitor;
    chk("reset", {ad_oe, up_oe, hb_oe, cg_oe, mg_oe, xfer_ready, xfer_done}, 25'h0);
    {tb_ad, tb_up, tb_hb} = {16'hA5C3, 4'h6, 1'b1};
    repeat (2) @(negedge ref_clk);
    chk("monitor", {mon_ad, mon_status}, {16'hA5C3, 5'h16});
    chk("no drive", {ad_oe, up_oe, hb_oe}, 21'h0);
    $display("test monitor done");
  endtask
  // single word write, fastest grant
  task automatic t_write;
    int lows;
    dly = 4'h0;
    lows = n_low;
    own_xfer(20'hA1234, 2'b11, 1'b1, 1'b1, 16'h5AC3, 0, 1'b1);
    chk("cpu pulses", 48'(n_low - lows), 48'h3);
    $display("test write done");
  endtask
  // high byte read with waits, then low byte write, one exchange
  task automatic t_burst;
    int lows;
    repeat (2) @(negedge ref_clk);
    dly = 4'h5;
    lows = n_low;
    own_xfer(20'h56789, 2'b10, 1'b0, 1'b0, 16'h9E71, 2, 1'b1);
    own_xfer(20'h30F0E, 2'b01, 1'b1, 1'b1, 16'h1B2D, 1, 1'b0);
    chk("cpu pulses", 48'(n_low - lows), 48'h3);
    $display("test burst done");
  endtask
  // relay a second master's exchange to the cpu
  task automatic t_relay;
    int t[6];
    int sel[6] = '{0, 1, 2, 3, 0, 1};
    int k;
    int lows;
    logic on;
    {k, on, dly, lows} = {32'h0, 1'b0, 4'h3, n_low};
    repeat (2) @(negedge ref_clk);
    mst_go = 1'b1;
    @(negedge ref_clk);
    mst_go = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (k < 6 && {mg_oe, cpu_pull, cg_oe, mst_pull}[sel[k]]) begin
        t[k] = i;
        k++;
      end
      on = on | (|{ad_oe, up_oe, hb_oe});
      @(negedge ref_clk);
    end
    chk("relay request", 48'(t[1] - t[0]), 48'h1);
    chk("relay grant", 48'(t[3] - t[2]), 48'h2);
    chk("relay release", 48'(t[5] - t[4]), 48'h1);
    chk("relay pulses", {48'(n_low - lows), on}, {48'h3, 1'b0});
    $display("test relay done");
  endtask
  // main sequence
  initial begin
    {rst_n, xfer_valid, xfer_write, xfer_last, mst_go, bus_ready} = 6'h01;
    {xfer_addr, xfer_be, xfer_wdata, dly} = 42'h0;
    {tb_ad, tb_up, tb_hb} = {16'h0000, 4'h0, 1'b1};
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    t_monitor();
    t_write();
    t_burst();
    t_relay();
    results();
  end
  // watchdog: the tests take under a hundred clocks
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_fail++;
    $display("BAD watchdog expected end seen timeout");
    results();
  end
endmodule
`default_nettype wire
